// ### src/crs_pkg.sv
// Shared constants and types for the CPU dedicated register set
package crs_pkg;

  // Bus widths
  localparam int DATA_W = 32;           // APB data width
  localparam int ADDR_W = 8;            // APB address width used here

  // Register byte offsets
  localparam logic [7:0] OFF_PC   = 8'h00;  // Program counter
  localparam logic [7:0] OFF_A    = 8'h04;  // Primary accumulator
  localparam logic [7:0] OFF_T    = 8'h08;  // Secondary accumulator
  localparam logic [7:0] OFF_IX   = 8'h0c;  // Index pointer
  localparam logic [7:0] OFF_EP   = 8'h10;  // Extra address pointer
  localparam logic [7:0] OFF_SP   = 8'h14;  // Stack pointer
  localparam logic [7:0] OFF_PS   = 8'h18;  // Program status word
  localparam logic [7:0] OFF_ALU  = 8'h1c;  // Flag operation command, write only
  localparam logic [7:0] OFF_BANK = 8'h20;  // Active bank base address, read only
  localparam logic [2:0] GPR_SEL  = 3'h2;   // paddr[7:5] of window 0x40..0x5c

  // Program status word fields
  localparam int PS_RP_LO  = 8;         // Bank select pointer, bits 15:8
  localparam int CCR_H     = 7;         // Half carry
  localparam int CCR_IE    = 6;         // Interrupt enable
  localparam int CCR_IL_HI = 5;         // Interrupt level, upper bit
  localparam int CCR_IL_LO = 4;         // Interrupt level, lower bit
  localparam int CCR_N     = 3;         // Negative
  localparam int CCR_Z     = 2;         // Zero
  localparam int CCR_V     = 1;         // Overflow
  localparam int CCR_C     = 0;         // Carry

  // Values after reset
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_A  = 16'h0000;
  localparam logic [15:0] RST_T  = 16'h0000;
  localparam logic [15:0] RST_IX = 16'h0000;
  localparam logic [15:0] RST_EP = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h0000;
  localparam logic [15:0] RST_PS = 16'h0030;  // Enable clear, level field 11

  // Memory position of bank zero
  localparam logic [15:0] GPR_BASE = 16'h0100;

  // Flag operations
  typedef enum logic [1:0] {
    ALU_ADD = 2'h0,
    ALU_SUB = 2'h1,
    ALU_SHL = 2'h2,
    ALU_SHR = 2'h3
  } crs_alu_op_e;

  // Bus slave states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RAM  = 3'b010,
    ST_DONE = 3'b100
  } crs_state_e;

  // APB request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } crs_apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } crs_apb_rsp_s;

  // Flags from one operation
  typedef struct packed {
    logic h;
    logic h_valid;
    logic n;
    logic z;
    logic v;
    logic c;
  } crs_flags_s;

endpackage

// ### src/crs_flag_unit.sv
// Byte operation and condition flag generation
`timescale 1ns/100ps
`default_nettype none
module crs_flag_unit
  import crs_pkg::*;
(
  // Operands and operation
  input  wire logic [7:0]  opa,
  input  wire logic [7:0]  opb,
  input  wire crs_alu_op_e op,
  // Result and flags
  output logic [7:0]       result,
  output crs_flags_s       flags
);

  logic [8:0] sum9;                     // Add with carry out
  logic [8:0] dif9;                     // Subtract with borrow out
  logic [4:0] nib5;                     // Low nibble add

  // Operation and flag terms
  always_comb
  begin
    sum9 = {1'b0, opa} + {1'b0, opb};
    dif9 = {1'b0, opa} - {1'b0, opb};
    nib5 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
    flags = '0;
    result = sum9[7:0];
    case (op)
      ALU_ADD:
      begin
        result = sum9[7:0];
        flags.c = sum9[8];
        flags.h = nib5[4];
        flags.h_valid = 1'b1;
        flags.v = (opa[7] == opb[7]) && (sum9[7] != opa[7]);
      end
      ALU_SUB:
      begin
        result = dif9[7:0];
        flags.c = dif9[8];
        flags.h = opa[3:0] < opb[3:0];
        flags.h_valid = 1'b1;
        flags.v = (opa[7] != opb[7]) && (dif9[7] != opa[7]);
      end
      // Shifts leave half carry alone and never overflow
      ALU_SHL:
      begin
        result = {opa[6:0], 1'b0};
        flags.c = opa[7];
      end
      ALU_SHR:
      begin
        result = {1'b0, opa[7:1]};
        flags.c = opa[0];
      end
      default:
      begin
        result = sum9[7:0];
      end
    endcase
    flags.n = result[7];
    flags.z = (result == 8'h00);
  end

endmodule
`default_nettype wire

// ### src/crs_bank_ram.sv
// Banked general-purpose register storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module crs_bank_ram #(
  parameter int AW = 7,                 // Address width
  parameter int DW = 8                  // Data width
)
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Access port
  input  wire logic          we,
  input  wire logic          re,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic [DW-1:0]      rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];     // Storage, no reset like real RAM

  // Write port
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata <= '0;
    end
    else if (re)
    begin
      rdata <= mem[addr];
    end
  end

endmodule
`default_nettype wire

// ### src/crs_core_regs.sv
// CPU dedicated register set with banked registers behind an APB slave
//
// Notes on behaviour
// - Sixteen-bit program counter, software readable and writable.
// - Sixteen-bit accumulator; byte operations use low byte.
// - Sixteen-bit second operand; byte operations low byte.
// - Sixteen-bit index pointer register.
// - Sixteen-bit extra address pointer register.
// - Sixteen-bit stack pointer register.
// - Status word: bank pointer high, flags low.
// - Bank pointer picks the active register bank.
// - Half carry on nibble carry or borrow.
// - Interrupt enable gates interrupts, cleared at reset.
// - Only requests below the level field are accepted.
// - Negative follows result most significant bit.
// - Zero set only for all-zero result.
// - Overflow on two's complement overflow.
// - Carry on carry or borrow at bit seven.
// - Shifts load carry with bit shifted out.
// - Byte registers, eight per bank, in RAM.
// - Eight banks for 128 bytes, sixteen for 256.
`timescale 1ns/100ps
`default_nettype none
module crs_core_regs
  import crs_pkg::*;
#(
  parameter int RAM_BYTES = 256         // Data RAM size, 128 or 256
)
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave
  input  wire crs_apb_req_s apb_req,
  output var  crs_apb_rsp_s apb_rsp,
  // Interrupt request from the controller
  input  wire logic         irq_req,
  input  wire logic [1:0]   irq_req_level,
  // Views for the core
  output var  logic         irq_accept,
  output var  logic [15:0]  bank_base
);

  // Bank count and storage size
  localparam int NB = RAM_BYTES / 16;
  localparam int BW = $clog2(NB);       // Bank number width
  localparam int RW = BW + 3;           // Storage address width

  // Refuse RAM sizes that have no bank count
  if (RAM_BYTES != 128 && RAM_BYTES != 256)
  begin : g_bad_ram
    $error("crs_core_regs: RAM_BYTES must be 128 or 256");
  end

  // All block state
  typedef struct packed {
    crs_state_e        state;           // Bus slave phase
    logic [ADDR_W-1:0] addr;            // Address caught at setup
    crs_apb_rsp_s      rsp;             // Bus answer
    logic [15:0]       pc;              // Program counter
    logic [15:0]       a;               // Primary accumulator
    logic [15:0]       t;               // Secondary accumulator
    logic [15:0]       ix;              // Index pointer
    logic [15:0]       ep;              // Extra address pointer
    logic [15:0]       sp;              // Stack pointer
    logic [15:0]       ps;              // Program status word
    logic [15:0]       bank_base;       // Base address of active bank
    logic              irq_accept;      // Interrupt admitted
  } crs_state_s;

  crs_state_s  st;                      // Current state
  crs_state_s  next_st;                 // Next state

  // Helper terms
  logic        setup;                   // Setup cycle of a transfer
  logic        gpr_hit;                 // Address falls in bank window
  logic        bank_ok;                 // Bank pointer names a real bank
  logic [1:0]  il;                      // Interrupt level field
  logic        alu_go;                  // Flag operation takes effect
  crs_alu_op_e alu_op;                  // Requested flag operation
  logic [7:0]  alu_res;                 // Byte result
  crs_flags_s  alu_flags;               // Flags of that result
  logic        ram_we;                  // Storage write
  logic        ram_re;                  // Storage read
  logic [RW-1:0] ram_addr;              // Storage address
  logic [7:0]  ram_q;                   // Storage read data

  assign setup   = apb_req.psel && !apb_req.penable;
  assign gpr_hit = (apb_req.paddr[7:5] == GPR_SEL);
  assign bank_ok = st.ps[15:PS_RP_LO] < 8'(NB);
  assign il      = st.ps[CCR_IL_HI:CCR_IL_LO];
  assign alu_op  = crs_alu_op_e'(apb_req.pwdata[1:0]);

  // Byte operation on the low bytes of both accumulators
  crs_flag_unit u_flags (
    .opa    (st.a[7:0]),
    .opb    (st.t[7:0]),
    .op     (alu_op),
    .result (alu_res),
    .flags  (alu_flags)
  );

  // Banked register storage, eight bytes per bank
  crs_bank_ram #(
    .AW (RW),
    .DW (8)
  ) u_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (ram_we),
    .re      (ram_re),
    .addr    (ram_addr),
    .wdata   (apb_req.pwdata[7:0]),
    .rdata   (ram_q)
  );

  // Next state: bus slave, register writes, flags and interrupt gate
  always_comb
  begin
    next_st = st;
    ram_we = 1'b0;
    ram_re = 1'b0;
    alu_go = 1'b0;
    ram_addr = {st.ps[PS_RP_LO +: BW], apb_req.paddr[4:2]};
    // Admit only below the level field and while enabled
    next_st.irq_accept = st.ps[CCR_IE] && irq_req && (irq_req_level < il);
    case (st.state)
      ST_IDLE:
      begin
        if (setup)
        begin
          next_st.addr = apb_req.paddr;
          next_st.rsp.pslverr = 1'b0;
          next_st.rsp.prdata = '0;
          if (gpr_hit && !bank_ok)
          begin
            // Pointer beyond the banks this RAM holds
            next_st.rsp.pslverr = 1'b1;
            next_st.rsp.pready = 1'b1;
            next_st.state = ST_DONE;
          end
          else if (gpr_hit && !apb_req.pwrite)
          begin
            // Storage read needs one more cycle for its data register
            ram_re = 1'b1;
            next_st.state = ST_RAM;
          end
          else
          begin
            next_st.rsp.pready = 1'b1;
            next_st.state = ST_DONE;
            case (apb_req.paddr)
              OFF_PC:   next_st.rsp.prdata = {16'h0000, st.pc};
              OFF_A:    next_st.rsp.prdata = {16'h0000, st.a};
              OFF_T:    next_st.rsp.prdata = {16'h0000, st.t};
              OFF_IX:   next_st.rsp.prdata = {16'h0000, st.ix};
              OFF_EP:   next_st.rsp.prdata = {16'h0000, st.ep};
              OFF_SP:   next_st.rsp.prdata = {16'h0000, st.sp};
              OFF_PS:   next_st.rsp.prdata = {16'h0000, st.ps};
              OFF_ALU:  next_st.rsp.prdata = '0;
              OFF_BANK: next_st.rsp.prdata = {16'h0000, st.bank_base};
              default:
              begin
                // Window writes land here too and are fine
                next_st.rsp.pslverr = !gpr_hit;
              end
            endcase
          end
        end
      end
      ST_RAM:
      begin
        next_st.rsp.prdata = {24'h000000, ram_q};
        next_st.rsp.pready = 1'b1;
        next_st.state = ST_DONE;
      end
      ST_DONE:
      begin
        if (apb_req.penable)
        begin
          // Transfer completes at this edge; writes act only here
          next_st.rsp.pready = 1'b0;
          next_st.rsp.pslverr = 1'b0;
          next_st.state = ST_IDLE;
          if (apb_req.pwrite && !st.rsp.pslverr)
          begin
            case (st.addr)
              OFF_PC: next_st.pc = apb_req.pwdata[15:0];
              OFF_A:  next_st.a  = apb_req.pwdata[15:0];
              OFF_T:  next_st.t  = apb_req.pwdata[15:0];
              OFF_IX: next_st.ix = apb_req.pwdata[15:0];
              OFF_EP: next_st.ep = apb_req.pwdata[15:0];
              OFF_SP: next_st.sp = apb_req.pwdata[15:0];
              OFF_PS: next_st.ps = apb_req.pwdata[15:0];
              OFF_ALU:
              begin
                alu_go = 1'b1;
              end
              OFF_BANK:
              begin
                // Read-only view, write ignored
                next_st.bank_base = st.bank_base;
              end
              default:
              begin
                ram_we = (st.addr[7:5] == GPR_SEL);
                ram_addr = {st.ps[PS_RP_LO +: BW], st.addr[4:2]};
              end
            endcase
          end
        end
      end
      default:
      begin
        next_st.state = ST_IDLE;
        next_st.rsp.pready = 1'b0;
      end
    endcase
    // Byte result goes to the low byte only, high byte is kept
    if (alu_go)
    begin
      next_st.a[7:0] = alu_res;
      next_st.ps[CCR_N] = alu_flags.n;
      next_st.ps[CCR_Z] = alu_flags.z;
      next_st.ps[CCR_V] = alu_flags.v;
      next_st.ps[CCR_C] = alu_flags.c;
      if (alu_flags.h_valid)
      begin
        next_st.ps[CCR_H] = alu_flags.h;
      end
    end
    // Base follows the pointer so it is never a cycle stale
    next_st.bank_base = GPR_BASE + {5'h00, next_st.ps[15:PS_RP_LO], 3'h0};
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st.state      <= ST_IDLE;
      st.addr       <= '0;
      st.rsp        <= '0;
      st.pc         <= RST_PC;
      st.a          <= RST_A;
      st.t          <= RST_T;
      st.ix         <= RST_IX;
      st.ep         <= RST_EP;
      st.sp         <= RST_SP;
      st.ps         <= RST_PS;
      st.bank_base  <= GPR_BASE;
      st.irq_accept <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign apb_rsp    = st.rsp;
  assign irq_accept = st.irq_accept;
  assign bank_base  = st.bank_base;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [8:0] chk_add;                  // Independent add of low bytes
  logic [4:0] chk_nib;                  // Independent nibble add
  assign chk_add = {1'b0, st.a[7:0]} + {1'b0, st.t[7:0]};
  assign chk_nib = {1'b0, st.a[3:0]} + {1'b0, st.t[3:0]};

  sequence s_gpr_read_setup;
    st.state == ST_IDLE && setup && gpr_hit && bank_ok && !apb_req.pwrite;
  endsequence

  sequence s_ram_answer;
    !apb_rsp.pready ##1 apb_rsp.pready;
  endsequence

  AST_IE_RESET: assert property ($rose(presetn) |-> !st.ps[CCR_IE])
    else $error("interrupt enable not clear after reset");
  AST_IRQ_GATE: assert property (
    (st.ps[CCR_IE] && irq_req && irq_req_level < il) |=> irq_accept)
    else $error("eligible interrupt not admitted");
  AST_IRQ_BLOCK: assert property (
    (!st.ps[CCR_IE] || il == 2'h0 || !irq_req) |=> !irq_accept)
    else $error("blocked interrupt admitted");
  AST_ADD_CARRY: assert property (
    alu_go && alu_op == ALU_ADD |=> st.ps[CCR_C] == $past(chk_add[8]))
    else $error("carry wrong after add");
  AST_ADD_HALF: assert property (
    alu_go && alu_op == ALU_ADD |=> st.ps[CCR_H] == $past(chk_nib[4]))
    else $error("half carry wrong after add");
  AST_SUB_OVF: assert property (
    alu_go && alu_op == ALU_SUB |=>
      st.ps[CCR_V] == ($past(st.a[7] != st.t[7]) && (st.a[7] != $past(st.a[7]))))
    else $error("overflow wrong after subtract");
  AST_ZERO_NEG: assert property (
    alu_go |=> st.ps[CCR_Z] == (st.a[7:0] == 8'h00) && st.ps[CCR_N] == st.a[7])
    else $error("zero or negative flag wrong");
  AST_HIGH_BYTE: assert property (
    alu_go |=> st.a[15:8] == $past(st.a[15:8]) && $stable(st.t))
    else $error("byte operation touched upper byte");
  AST_SHL_CARRY: assert property (
    alu_go && alu_op == ALU_SHL |=> st.ps[CCR_C] == $past(st.a[7]))
    else $error("shift carry wrong");
  AST_BANK_BASE: assert property (
    bank_base == GPR_BASE + {5'h00, st.ps[15:PS_RP_LO], 3'h0})
    else $error("bank base does not follow pointer");
  AST_GPR_READ: assert property (s_gpr_read_setup |=> s_ram_answer)
    else $error("bank register read timing wrong");

endmodule
`default_nettype wire

// ### tb/crs_core_regs_tb.sv
// Self-checking bench for the CPU dedicated register set
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module crs_core_regs_tb
  import crs_pkg::*;
;
  // Design connections
  logic         pclk;
  logic         presetn;
  crs_apb_req_s apb_req;
  crs_apb_rsp_s apb_rsp;
  logic         irq_req;
  logic [1:0]   irq_req_level;
  logic         irq_accept;
  logic [15:0]  bank_base;
  // Bookkeeping
  int           errors;
  int           total_checks;
  int           cycles;
  logic [31:0]  seed;          // Random source
  logic [33:0]  expq[$];       // Notes: {check data, error, data}
  logic [33:0]  cur;           // Note under comparison
  logic [15:0]  ps;            // Shadow of the status word
  logic [15:0]  regv[6];       // Shadow of the six word registers
  logic [7:0]   gpr[3][8];     // Shadow of three banks
  logic [7:0]   ta[5] = '{8'h7f, 8'hff, 8'h00, 8'h80, 8'h0f};
  logic [7:0]   tt[5] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h01};
  logic [3:0]   rps[3] = '{4'h0, 4'h1, 4'hf};

  crs_core_regs #(.RAM_BYTES(256)) dut
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .apb_req       (apb_req),
    .apb_rsp       (apb_rsp),
    .irq_req       (irq_req),
    .irq_req_level (irq_req_level),
    .irq_accept    (irq_accept),
    .bank_base     (bank_base)
  );

  // Clock, 10 ns period
  always #5 pclk = ~pclk;

  // Taps give a long sequence; any nonzero start works
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected flag byte and result of one byte operation
  function automatic logic [7:0] flags(input logic [1:0] op, input logic [7:0] a,
                                       input logic [7:0] t, input logic [7:0] old,
                                       output logic [7:0] r);
    logic [8:0] s;
    logic       h;
    logic       v;
    h = old[7];                 // Shifts leave half carry alone
    v = 1'b0;
    case (op)
      2'd0:
      begin
        s = {1'b0, a} + {1'b0, t};
        h = ({1'b0, a[3:0]} + {1'b0, t[3:0]}) > 5'd15;
        v = (a[7] == t[7]) && (s[7] != a[7]);
      end
      2'd1:
      begin
        s = {1'b0, a} - {1'b0, t};  // Top bit is the borrow
        h = a[3:0] < t[3:0];
        v = (a[7] != t[7]) && (s[7] != a[7]);
      end
      2'd2: s = {a, 1'b0};
      default: s = {a[0], 1'b0, a[7:1]};
    endcase
    r = s[7:0];
    return {h, old[6:4], s[7], s[7:0] == 8'h00, v, s[8]};
  endfunction

  // One APB transfer; the note is queued before the bus moves
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     input logic chk, input logic err, input logic [31:0] ex);
    expq.push_back({chk, err, ex});
    @(posedge pclk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= ad;
    apb_req.pwdata  <= wd;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // Plain write and checked read
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd, 1'b0, 1'b0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
    apb(1'b0, ad, 32'h0, 1'b1, 1'b0, ex);
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Monitor: every completed transfer takes the oldest note
  always @(posedge pclk)
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1)
    begin
      cur = expq.pop_front();
      `CHK("pslverr", cur[32], apb_rsp.pslverr)
      if (cur[33])
        `CHK("prdata", cur[31:0], apb_rsp.prdata)
    end

  // Hang guard, far above the thousand or so cycles needed
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      conclude();
    end
  end

  // Main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    apb_req = '0;
    irq_req = 1'b0;
    irq_req_level = 2'h0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    seed = 32'h4cd5ba27;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    `CHK("bank_base", 16'h0100, bank_base)
    `CHK("irq_accept", 1'b0, irq_accept)
    for (int i = 0; i < 6; i++)
      rd(8'(i * 4), 32'h0);
    rd(OFF_PS, 32'h0030);
    $display("test reset done");
    // Program counter, accumulators and pointers, random values, upper word must read zero
    for (int n = 0; n < 3; n++)
    begin
      for (int i = 0; i < 6; i++)
      begin
        seed = lfsr(seed);
        regv[i] = seed[15:0];
        wr(8'(i * 4), seed);
      end
      for (int i = 0; i < 6; i++)
        rd(8'(i * 4), {16'h0, regv[i]});
    end
    $display("test registers done");
    // Banks: base follows pointer, banks kept apart, last bank usable
    for (int b = 0; b < 3; b++)
    begin
      wr(OFF_PS, {16'h0, 4'h0, rps[b], 8'h30});
      #1 `CHK("bank_base", 16'h0100 + 16'(rps[b]) * 16'd8, bank_base)
      for (int i = 0; i < 8; i++)
      begin
        seed = lfsr(seed);
        gpr[b][i] = seed[7:0];
        wr(8'h40 + 8'(i * 4), seed);
      end
    end
    for (int b = 0; b < 3; b++)
    begin
      wr(OFF_PS, {16'h0, 4'h0, rps[b], 8'h30});
      for (int i = 0; i < 8; i++)
        rd(8'h40 + 8'(i * 4), {24'h0, gpr[b][i]});
    end
    rd(OFF_BANK, 32'h0178);
    wr(OFF_PS, 32'h1030);
    apb(1'b0, 8'h5c, 32'h0, 1'b1, 1'b1, 32'h0);
    apb(1'b1, 8'h40, 32'h5a, 1'b0, 1'b1, 32'h0);
    apb(1'b0, 8'h24, 32'h0, 1'b1, 1'b1, 32'h0);
    wr(OFF_BANK, 32'h0);
    rd(OFF_BANK, 32'h0180);
    $display("test banks done");
    // Byte operations and flags, boundary operands then random ones
    ps = 16'h0030;
    wr(OFF_PS, {16'h0, ps});
    for (int op = 0; op < 4; op++)
      for (int k = 0; k < 6; k++)
      begin
        logic [7:0] a;
        logic [7:0] t;
        logic [7:0] r;
        seed = lfsr(seed);
        a = (k < 5) ? ta[k] : seed[7:0];
        t = (k < 5) ? tt[k] : seed[15:8];
        regv[1] = {seed[23:16], a};
        regv[2] = {seed[31:24], t};
        wr(OFF_A, {16'h0, regv[1]});
        wr(OFF_T, {16'h0, regv[2]});
        wr(OFF_ALU, {30'h0, 2'(op)});
        ps[7:0] = flags(2'(op), a, t, ps[7:0], r);
        rd(OFF_A, {16'h0, regv[1][15:8], r});
        rd(OFF_T, {16'h0, regv[2]});
        rd(OFF_PS, {16'h0, ps});
      end
    $display("test flags done");
    // Interrupt gating over every enable, level field and request level
    for (int ie = 0; ie < 2; ie++)
      for (int il = 0; il < 4; il++)
        for (int lv = 0; lv < 4; lv++)
        begin
          wr(OFF_PS, {24'h0, 1'b0, 1'(ie), 2'(il), 4'h0});
          irq_req <= 1'b1;
          irq_req_level <= 2'(lv);
          @(posedge pclk);
          @(posedge pclk);
          #1 `CHK("irq_accept", 1'((ie == 1) && (lv < il)), irq_accept)
        end
    irq_req <= 1'b0;
    irq_req_level <= 2'h0;
    @(posedge pclk);
    @(posedge pclk);
    #1 `CHK("irq_accept", 1'b0, irq_accept)
    $display("test interrupts done");
    repeat (2) @(posedge pclk);
    `CHK("notes left", 0, expq.size())
    conclude();
  end
endmodule
`default_nettype wire
